// file: rtl/mie_slave.v
// Two-wire slave giving access to the 256-byte module information store.
`timescale 1ns/1ps
`include "mie_consts.vh"

// Overview of operation
// - Data changes only while clock low
// - Start is data fall with clock high
// - Ignore bus until a start is seen
// - Stop is data rise with clock high
// - Stop returns slave to standby
// - Transmitter releases data after eight bits
// - Receiver pulls data low on ninth clock
// - Acknowledge own address after start
// - Acknowledge every byte written after address
// - Read: shift eight bits, sample master acknowledge
// - Master acknowledge continues with next byte
// - No acknowledge: release, await stop
// - Store holds 256 bytes, 2048 bits
// - Upper 128 bytes reserved for user
// - Three straps form low address bits
// - Write protect blocks store writes
// - Transfers follow master serial clock
module mie_slave #(
  parameter STORE_BYTES = `MIE_STORE_BYTES
) (
  input  wire core_clk,
  input  wire rst_n,
  input  wire scl_in,
  input  wire sda_in,
  output wire sda_out,
  output reg  sda_oe,
  input  wire addr_strap_0,
  input  wire addr_strap_1,
  input  wire addr_strap_2,
  input  wire write_protect,
  output wire standby,
  output wire addressed
);

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  // Idle waits for a start, the address state takes the first byte, the word
  // state takes the pointer, write data stores bytes, read data sends bytes,
  // and wait keeps the line released until the next start or stop.
  localparam ST_IDLE  = 6'b000001;
  localparam ST_DADR  = 6'b000010;
  localparam ST_WORD  = 6'b000100;
  localparam ST_WDATA = 6'b001000;
  localparam ST_RDATA = 6'b010000;
  localparam ST_WAIT  = 6'b100000;

  reg                   rst_meta_n;
  reg                   rst_sync_n;
  wire                  scl_s;
  wire                  sda_s;
  wire                  wp_s;
  wire                  sa0_s;
  wire                  sa1_s;
  wire                  sa2_s;
  reg                   scl_d;
  reg                   sda_d;
  reg [5:0]             state;
  reg [3:0]             bit_cnt;
  reg [7:0]             shift;
  reg [`MIE_ADDR_W-1:0] ptr;
  reg                   ack_phase;
  reg [7:0]             store [0:STORE_BYTES-1];
  wire                  scl_rise;
  wire                  scl_fall;
  wire                  start_det;
  wire                  stop_det;
  wire [6:0]            own_addr;
  wire [7:0]            rd_byte;
  wire                  store_we;
  integer               i;

  // ---------------------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------------------
  // Reset is released through two flip-flops.
  // Assertion is immediate; release waits two clocks so no flop sees a runt.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Every pin passes two flip-flops before any logic reads it. The straps and
  // the write protect are slow levels, but they come from pins all the same
  // and may change at any moment.
  mie_sync #(.RST_VAL(1'b1)) u_scl (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .pin_in(scl_in),
    .pin_sync(scl_s));
  mie_sync #(.RST_VAL(1'b1)) u_sda (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .pin_in(sda_in),
    .pin_sync(sda_s));
  mie_sync #(.RST_VAL(1'b1)) u_wp  (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .pin_in(write_protect),
    .pin_sync(wp_s));
  mie_sync #(.RST_VAL(1'b1)) u_sa0 (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .pin_in(addr_strap_0),
    .pin_sync(sa0_s));
  mie_sync #(.RST_VAL(1'b1)) u_sa1 (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .pin_in(addr_strap_1),
    .pin_sync(sa1_s));
  mie_sync #(.RST_VAL(1'b1)) u_sa2 (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .pin_in(addr_strap_2),
    .pin_sync(sa2_s));

  // ---------------------------------------------------------------------------
  // Edge and condition detection
  // ---------------------------------------------------------------------------
  // Delayed copies of the synchronised lines for edge finding.
  // The delayed copies form a third stage, so a start or stop is seen about
  // three clocks after it happens on the pins.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  assign own_addr  = {`MIE_DEV_TYPE, sa2_s, sa1_s, sa0_s};
  // Read data comes straight from the store at the pointer.
  assign rd_byte   = store[ptr];
  // Standby and addressed are decoded from the one-hot state register.
  assign standby   = state[0];
  assign addressed = ~state[0] & ~state[1] & ~state[5];
  assign sda_out   = 1'b0;

  // ---------------------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------------------
  // Bits are sampled on clock rise and the data line is changed on clock fall.
  // The bit counter runs 0 to 8 while a byte comes in, and the acknowledge
  // phase flag then marks the ninth clock. While a byte goes out it runs 1 to
  // 8, then 9 while the master's acknowledge is awaited, and 10 between that
  // acknowledge and the next byte.
  // A start or stop on the pins overrides the engine in any state, so the
  // master may abandon a transfer at any point.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state     <= ST_IDLE;
      bit_cnt   <= `MIE_BITCNT_RST;
      shift     <= 8'h00;
      ptr       <= `MIE_PTR_RST;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (start_det) begin
      state     <= ST_DADR;
      bit_cnt   <= `MIE_BITCNT_RST;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (stop_det) begin
      state     <= ST_IDLE;
      ack_phase <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_WAIT: begin
          // A foreign address or a refused read byte parks the engine here.
          // Released until the next start or stop
          sda_oe <= 1'b0;
        end
        ST_DADR, ST_WORD, ST_WDATA: begin
          if (!ack_phase) begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt   <= `MIE_BITCNT_RST;
              ack_phase <= 1'b1;
              if (state == ST_DADR) begin
                if (shift[7:1] == own_addr) begin
                  sda_oe <= 1'b1;
                  if (shift[`MIE_RW_BIT])
                    state <= ST_RDATA;
                  else
                    state <= ST_WORD;
                end else begin
                  sda_oe <= 1'b0;
                  state  <= ST_WAIT;
                end
              end else if (state == ST_WORD) begin
                sda_oe <= 1'b1;
                ptr    <= shift;
                state  <= ST_WDATA;
              end else begin
                sda_oe <= 1'b1;
                ptr    <= ptr + 8'h01;
              end
            end
          end else if (scl_fall) begin
            ack_phase <= 1'b0;
            if (state == ST_RDATA) begin
              sda_oe  <= ~rd_byte[7];
              shift   <= {rd_byte[6:0], 1'b1};
              bit_cnt <= 4'h1;
            end else begin
              sda_oe <= 1'b0;
            end
          end
        end
        ST_RDATA: begin
          if (ack_phase) begin
            // Address acknowledge cycle ahead of the first read byte.
            if (scl_fall) begin
              ack_phase <= 1'b0;
              sda_oe    <= ~rd_byte[7];
              shift     <= {rd_byte[6:0], 1'b1};
              bit_cnt   <= 4'h1;
            end
          end else if (bit_cnt == 4'h9) begin
            // A high line at the ninth rising clock is the master refusing.
            // Sample master acknowledge
            if (scl_rise) begin
              if (sda_s) begin
                state <= ST_WAIT;
              end else begin
                bit_cnt <= 4'ha;
              end
            end
          end else if (bit_cnt == 4'ha) begin
            if (scl_fall) begin
              sda_oe  <= ~rd_byte[7];
              shift   <= {rd_byte[6:0], 1'b1};
              bit_cnt <= 4'h1;
            end
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe  <= 1'b0;
              bit_cnt <= 4'h9;
              ptr     <= ptr + 8'h01;
            end else begin
              sda_oe  <= ~shift[7];
              shift   <= {shift[6:0], 1'b1};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Information store
  // ---------------------------------------------------------------------------
  // A data byte is stored on its eighth falling clock, with the pointer value
  // from before it advances. A start or stop in the same cycle wins.
  // Write protect gate
  assign store_we  = rst_sync_n & ~start_det & ~stop_det & (state == ST_WDATA) & ~ack_phase &
                     scl_fall & (bit_cnt == 4'h8) & ~wp_s;

  // A protected write is still acknowledged, so the master sees no difference.
  // Byte store write port
  // Whole range writable, user half included
  always @(posedge core_clk) begin
    if (store_we) begin
      store[ptr] <= shift;
    end
  end

  // The store starts blank, with every bit set.
  // Contents last for one simulation run only.
  initial begin
    for (i = 0; i < STORE_BYTES; i = i + 1)
      store[i] = 8'hff;
  end

endmodule

// file: rtl/mie_consts.vh
// Constants for the module information store two-wire slave.
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
// ---------------------------------------------------------------------------
// Store layout
// ---------------------------------------------------------------------------
`define MIE_STORE_BYTES      256
`define MIE_ADDR_W           8
`define MIE_USER_BASE        8'h80
// ---------------------------------------------------------------------------
// Bus address
// ---------------------------------------------------------------------------
`define MIE_DEV_TYPE         4'ha
`define MIE_RW_BIT           0
// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define MIE_PTR_RST          8'h00
`define MIE_BITCNT_RST       4'h0
`endif

// file: rtl/mie_sync.v
// Two flip-flop synchroniser for one pin input.
`timescale 1ns/1ps
module mie_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire core_clk,
  input  wire rst_sync_n,
  input  wire pin_in,
  output reg  pin_sync
);

  reg stage_a;

  // The first stage is read only by the second stage.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stage_a  <= RST_VAL;
      pin_sync <= RST_VAL;
    end else begin
      stage_a  <= pin_in;
      pin_sync <= stage_a;
    end
  end

endmodule

// file: dv/mie_slave_chk.sv
// Pin checker for the store slave.
`timescale 1ns/1ps
module mie_slave_chk (
  input logic core_clk,
  input logic rst_n,
  input logic scl_in,
  input logic sda_in,
  input logic sda_out,
  input logic sda_oe,
  input logic standby,
  input logic addressed
);
  reg       in_frame;
  reg [3:0] since_fall;
  reg       scl_q;
  reg       sda_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sequence s_held;
    ##[0:8] (scl_in && sda_oe);
  endsequence
  // Frame flag between start and stop, and cycles since the last clock fall.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame   <= 1'b0;
      since_fall <= 4'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (scl_in && scl_q && sda_q && !sda_in)
        in_frame <= 1'b1;
      else if (scl_in && scl_q && !sda_q && sda_in)
        in_frame <= 1'b0;
      if (scl_q && !scl_in)
        since_fall <= 4'h0;
      else if (since_fall != 4'hf)
        since_fall <= since_fall + 4'h1;
    end
  end
  a_stop_standby: assert property (s_stop |-> ##[1:8] standby)
    else $error("standby late after stop");
  a_wake_start: assert property ($fell(standby) |-> in_frame)
    else $error("standby left without start");
  a_idle_free: assert property (standby && $past(standby) |-> !sda_oe)
    else $error("line driven in standby");
  a_frame_free: assert property (!in_frame |-> !sda_oe)
    else $error("line driven outside a frame");
  a_addr_frame: assert property ($rose(addressed) |-> in_frame)
    else $error("addressed without start");
  a_drive_held: assert property ($rose(sda_oe) |-> s_held)
    else $error("drive dropped before clock high");
  a_bit_length: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("drive shorter than a bit");
  a_oe_after_fall: assert property ($changed(sda_oe) |-> since_fall < 4'h7)
    else $error("drive changed away from clock fall");
  a_drive_low: assert property (sda_oe |-> !sda_out)
    else $error("driven level not low");
endmodule

bind mie_slave mie_slave_chk i_mie_slave_chk (
  .core_clk  (core_clk),
  .rst_n     (rst_n),
  .scl_in    (scl_in),
  .sda_in    (sda_in),
  .sda_out   (sda_out),
  .sda_oe    (sda_oe),
  .standby   (standby),
  .addressed (addressed)
);

// file: dv/mie_host_model.sv
// Two-wire bus master model making the serial clock and data line.
`timescale 1ns/1ps
module mie_host_model (
  input  wire core_clk,
  input  wire slave_oe,
  input  wire slave_out,
  output reg  scl,
  output wire sda
);
  reg m_low;
  assign sda = (slave_oe ? slave_out : 1'b1) & !m_low;
  // Clock stands high and the line is released when idle.
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end
  // Quarter of a 160 ns serial period.
  task tick;
    begin
      repeat (2) @(posedge core_clk);
      #1;
    end
  endtask
  task start;
    begin
      tick;
      tick;
      m_low = 1'b0;
      tick;
      scl = 1'b1;
      tick;
      m_low = 1'b1;
      tick;
      scl = 1'b0;
    end
  endtask
  task stop;
    begin
      tick;
      m_low = 1'b1;
      tick;
      scl = 1'b1;
      tick;
      m_low = 1'b0;
      tick;
    end
  endtask
  task bit_io(input b, output r);
    begin
      tick;
      m_low = !b;
      tick;
      scl = 1'b1;
      tick;
      r = sda;
      tick;
      scl = 1'b0;
    end
  endtask
  task wr_byte(input [7:0] d, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], ack);
      end
      bit_io(1'b1, ack);
    end
  endtask
  task rd_byte(output [7:0] d, input nak);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(1'b1, d[i]);
      end
      bit_io(nak, r);
    end
  endtask
endmodule

// file: dv/mie_slave_tb.sv
// Self-checking bench for the store slave.
`timescale 1ns/1ps
`include "mie_consts.vh"
module mie_slave_tb;
  reg         core_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         write_protect = 1'b0;
  reg  [2:0]  strap = 3'h5;
  wire        scl;
  wire        sda;
  wire        sda_out;
  wire        sda_oe;
  wire        standby;
  wire        addressed;
  integer     n_errors = 0;
  integer     check_count = 0;
  reg  [7:0]  rx;
  reg         ack;
  localparam [7:0] ADR = {`MIE_DEV_TYPE, 3'h5, 1'b0};
  always #10 core_clk = ~core_clk;
  mie_slave i_mie_slave (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
    .addr_strap_2(strap[2]), .write_protect(write_protect), .standby(standby), .addressed(addressed));
  mie_host_model i_mie_host_model (.core_clk(core_clk), .slave_oe(sda_oe), .slave_out(sda_out),
    .scl(scl), .sda(sda));
  // Comparison with counting and a report on mismatch.
  task chk(input [8*9:1] what, input [7:0] exp, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task send(input [7:0] d, input [7:0] exp_ack);
    begin
      i_mie_host_model.wr_byte(d, ack);
      chk("ack", exp_ack, {7'h0, ack});
    end
  endtask
  task fin;
    begin
      i_mie_host_model.stop;
      repeat (8) @(posedge core_clk);
      #1;
      chk("standby", 8'h01, {7'h0, standby});
      chk("sda_oe", 8'h00, {7'h0, sda_oe});
      chk("sda_out", 8'h00, {7'h0, sda_out});
    end
  endtask
  task write_at(input [7:0] p, input [7:0] d0, input [7:0] d1);
    begin
      i_mie_host_model.start;
      send(ADR, 8'h00);
      send(p, 8'h00);
      chk("addressed", 8'h01, {7'h0, addressed});
      send(d0, 8'h00);
      send(d1, 8'h00);
      fin;
    end
  endtask
  task read_at(input [7:0] p, input [7:0] d0, input [7:0] d1);
    begin
      i_mie_host_model.start;
      send(ADR, 8'h00);
      send(p, 8'h00);
      i_mie_host_model.start;
      send(ADR | 8'h01, 8'h00);
      i_mie_host_model.rd_byte(rx, 1'b0);
      chk("data0", d0, rx);
      i_mie_host_model.rd_byte(rx, 1'b1);
      chk("data1", d1, rx);
      chk("addressed", 8'h00, {7'h0, addressed});
      chk("sda_oe", 8'h00, {7'h0, sda_oe});
      fin;
    end
  endtask
  // Bytes without start, a foreign address, then a moved strap.
  task t_ignored;
    begin
      send(ADR, 8'h01);
      i_mie_host_model.start;
      send({`MIE_DEV_TYPE, 3'h2, 1'b0}, 8'h01);
      chk("addressed", 8'h00, {7'h0, addressed});
      send(8'h80, 8'h01);
      fin;
      strap = 3'h2;
      i_mie_host_model.start;
      send({`MIE_DEV_TYPE, 3'h2, 1'b0}, 8'h00);
      fin;
      strap = 3'h5;
      $display("t_ignored done");
    end
  endtask
  task t_write_read;
    begin
      write_at(8'h80, 8'h5a, 8'ha5);
      read_at(8'h80, 8'h5a, 8'ha5);
      $display("t_write_read done");
    end
  endtask
  task t_protect;
    begin
      write_protect = 1'b1;
      write_at(8'h80, 8'h00, 8'h00);
      write_protect = 1'b0;
      read_at(8'h80, 8'h5a, 8'ha5);
      $display("t_protect done");
    end
  endtask
  task t_wrap;
    begin
      write_at(8'hff, 8'h11, 8'h22);
      read_at(8'hff, 8'h11, 8'h22);
      $display("t_wrap done");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    chk("standby", 8'h01, {7'h0, standby});
    t_ignored;
    t_write_read;
    t_protect;
    t_wrap;
    print_verdict;
  end
  // Watchdog well beyond the expected run of about 50 us.
  initial begin
    #300000;
    n_errors = n_errors + 1;
    print_verdict;
  end
endmodule
